// *** src/cgc_defs.svh ***
`ifndef CGC_DEFS_SVH
`define CGC_DEFS_SVH

// Register addresses in the special-function space
`define CGC_ADDR_GIT      8'h9b
`define CGC_ADDR_TEC      8'h9c
`define CGC_ADDR_REC      8'h9d
`define CGC_ADDR_TCON     8'ha1
`define CGC_ADDR_TTCL     8'ha4
`define CGC_ADDR_TTCH     8'ha5
`define CGC_ADDR_GSTA     8'haa
`define CGC_ADDR_GCON     8'hab
`define CGC_ADDR_TIML     8'hac
`define CGC_ADDR_TIMH     8'had
`define CGC_ADDR_GIE      8'hc1

// General control bit positions
`define CGC_GCON_ABORT_REQUEST     7
`define CGC_GCON_OVERLOAD_REQUEST     6
`define CGC_GCON_TTC      5
`define CGC_GCON_SYNC     4
`define CGC_GCON_LISTEN   3
`define CGC_GCON_TEST     2
`define CGC_GCON_ENA      1
`define CGC_GCON_SRST     0

// General interrupt flag bit positions
`define CGC_GIT_ANY       7
`define CGC_GIT_TIMER_OVERRUN_FLAG    5
`define CGC_GIT_BUFFER_OVERRUN_FLAG    4
`define CGC_GIT_GENERAL_STUFF_ERROR      3
`define CGC_GIT_GENERAL_CRC_ERROR      2
`define CGC_GIT_GENERAL_FORM_ERROR      1
`define CGC_GIT_GENERAL_ACK_ERROR      0

// Interrupt enable bit positions
`define CGC_GIE_BUFFER_FULL_INTERRUPT_ENABLE     2
`define CGC_GIE_GENERAL_ERROR_INTERRUPT_ENABLE     1

// Reset values
`define CGC_RST_GCON      8'h00
`define CGC_RST_GIE       8'hc0
`define CGC_RST_GIT       8'h00
`define CGC_RST_CNT       8'h00
`define CGC_RST_TCON      8'h00
`define CGC_RST_TIMER     16'h0000

// Timing and thresholds
`define CGC_START_PERIODS 2
`define CGC_START_LAST    1'h1
`define CGC_PASSIVE_LIM   8'h80
`define CGC_CNT_MAX       8'hff
`define CGC_TIMER_MAX     16'hffff

`endif

// *** src/cgc_pkg.sv ***
package cgc_pkg;

  // Controller activity modes
  typedef enum logic [1:0] {CGC_OFF, CGC_START, CGC_RUN, CGC_STOP} cgc_mode_type;

  // Register port request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cgc_sfr_type;

  // Events from the protocol engine, one-cycle pulses or levels
  typedef struct packed {
    logic sof;
    logic eof_last;
    logic overload_start;
    logic overload_active;
    logic tx_frame;
    logic frame_pending;
    logic rx_frame;
    logic buffer_full;
    logic stuff_err;
    logic crc_err;
    logic form_err;
    logic ack_err;
  } cgc_event_type;

  // Error counter steps from the protocol engine
  typedef struct packed {
    logic tec_up8;
    logic tec_down;
    logic rec_up1;
    logic rec_up8;
    logic rec_down;
  } cgc_count_type;

  // Controls toward the protocol engine
  typedef struct packed {
    logic run;
    logic clk_en;
    logic overload_req;
    logic abort_req;
    logic tt_mode;
    logic listen_only;
    logic passive;
    logic bus_off;
  } cgc_core_type;

  // Whole state of the block
  typedef struct packed {
    cgc_mode_type mode;
    logic         start_cnt;
    logic         soft_rst;
    logic [7:0]   gcon;
    logic [7:0]   gie;
    logic [5:0]   flags;
    logic [7:0]   tec;
    logic [7:0]   rec;
    logic [7:0]   tcon;
    logic [7:0]   presc;
    logic [15:0]  timer;
    logic [15:0]  capture;
    logic         overload_sending;
    logic         transmitter_busy;
    logic         receiver_busy;
    logic [1:0]   rx_sync;
    logic         rx_out;
    logic         tx_pin;
    logic         irq;
    logic [7:0]   rdata;
    cgc_core_type core;
  } cgc_state_type;

endpackage

// *** src/cgc_top.sv ***
`timescale 1ns/1ps
`include "cgc_defs.svh"

// Operation
// - Overload request sends overload frame after next reception; cleared when it starts.
// - Time-triggered bit turns time-triggered features on or off.
// - In time-triggered mode capture point selects end-of-frame or start-of-frame capture.
// - Setting enable starts the controller and its clock.
// - Clearing enable lets current traffic finish, then freezes the controller.
// - Standby drives recessive, disables receiver and stops controller clock.
// - Registers stay readable and writable while disabled.
// - Controller starts running two clock periods after enabling.
// - Software reset acts like hardware reset, clears itself, leaves controller disabled.
// - Overload-sending status is high while our overload frame is sent.
// - Transmitter busy covers frames, acknowledge and pending interframe spacing.
// - Enabled-state status shows the mode in force, not the requested one.
// - Buffer-overrun flag sets when receive buffer fills; software clears it.
// - CRC mismatch on received message sets general CRC error flag.
// - Violated CRC delimiter, acknowledge delimiter or end of frame sets form error.
// - Transmit error count is read-only, resets to zero.
// - Receive error count is read-only, resets to zero.
// - Timer rollover from all ones to zero sets the timer-overrun flag.
// - Error-passive node sends passive error frames and waits between transmissions.
// - Buffer-full interrupt needs only the buffer-full enable; no global enable bit is used.
// - Bus-off node does not influence the bus.
module cgc_top (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire cgc_pkg::cgc_sfr_type   sfr,
  output logic [7:0]                  sfr_rdata,
  input  wire cgc_pkg::cgc_event_type ev,
  input  wire cgc_pkg::cgc_count_type cnt,
  input  wire logic                   core_tx,
  input  wire logic                   rx_pin,
  output logic                        tx_pin,
  output logic                        core_rx,
  output cgc_pkg::cgc_core_type       core,
  output logic [15:0]                 tt_capture,
  output logic                        general_irq
);

  localparam cgc_pkg::cgc_state_type RESET_STATE = '{
    mode: cgc_pkg::CGC_OFF, start_cnt: 1'h0, soft_rst: 1'h0,
    gcon: `CGC_RST_GCON, gie: `CGC_RST_GIE, flags: 6'h00,
    tec: `CGC_RST_CNT, rec: `CGC_RST_CNT, tcon: `CGC_RST_TCON, presc: 8'h00,
    timer: `CGC_RST_TIMER, capture: `CGC_RST_TIMER,
    overload_sending: 1'h0, transmitter_busy: 1'h0, receiver_busy: 1'h0, rx_sync: 2'h3, rx_out: 1'h1,
    tx_pin: 1'h1, irq: 1'h0, rdata: 8'h00, core: '0};

  cgc_pkg::cgc_state_type st;
  cgc_pkg::cgc_state_type next_st;
  logic                   wr_gcon;
  logic                   tick;
  logic                   running;
  logic                   busy;

  // Decoded strobes and shared terms
  assign wr_gcon = sfr.wr && (sfr.addr == `CGC_ADDR_GCON);
  assign running = (st.mode == cgc_pkg::CGC_RUN) || (st.mode == cgc_pkg::CGC_STOP);
  assign tick    = running && (st.presc == st.tcon);
  assign busy    = st.transmitter_busy || st.receiver_busy;

  // Next-state logic
  always_comb
  begin
    next_st = st;
    // Register writes, accepted whatever the mode
    if (sfr.wr)
    begin
      unique case (sfr.addr)
        `CGC_ADDR_GCON:
        begin
          next_st.gcon = sfr.wdata;
          next_st.gcon[`CGC_GCON_SRST] = 1'h0;
          next_st.soft_rst = sfr.wdata[`CGC_GCON_SRST];
        end
        `CGC_ADDR_GIE:  next_st.gie = sfr.wdata;
        `CGC_ADDR_TCON: next_st.tcon = sfr.wdata;
        `CGC_ADDR_GIT:  next_st.flags = st.flags & ~sfr.wdata[5:0];
        default:        next_st.gcon = st.gcon;
      endcase
    end
    // Overload request ends when our overload frame begins, unless rewritten
    if (ev.overload_start && !wr_gcon)
    begin
      next_st.gcon[`CGC_GCON_OVERLOAD_REQUEST] = 1'h0;
    end
    // Enable sequence: two periods to start, stop waits for the bus to go idle
    unique case (st.mode)
      cgc_pkg::CGC_OFF:
      begin
        if (st.gcon[`CGC_GCON_ENA])
        begin
          next_st.mode = cgc_pkg::CGC_START;
          next_st.start_cnt = 1'h0;
        end
      end
      cgc_pkg::CGC_START:
      begin
        next_st.start_cnt = 1'h1;
        if (!st.gcon[`CGC_GCON_ENA])
          next_st.mode = cgc_pkg::CGC_OFF;
        else if (st.start_cnt == `CGC_START_LAST)
          next_st.mode = cgc_pkg::CGC_RUN;
      end
      cgc_pkg::CGC_RUN:
      begin
        if (!st.gcon[`CGC_GCON_ENA])
          next_st.mode = cgc_pkg::CGC_STOP;
      end
      cgc_pkg::CGC_STOP:
      begin
        if (st.gcon[`CGC_GCON_ENA])
          next_st.mode = cgc_pkg::CGC_RUN;
        else if (!busy && !ev.tx_frame && !ev.rx_frame)
          next_st.mode = cgc_pkg::CGC_OFF;
      end
    endcase
    // Activity status mirrored from the protocol engine
    next_st.overload_sending = ev.overload_active;
    next_st.transmitter_busy = ev.tx_frame || (ev.frame_pending && running);
    next_st.receiver_busy = ev.rx_frame;
    // Sticky flags; an event wins over a clear in the same cycle
    if (ev.buffer_full)
      next_st.flags[`CGC_GIT_BUFFER_OVERRUN_FLAG] = 1'h1;
    if (ev.crc_err)
      next_st.flags[`CGC_GIT_GENERAL_CRC_ERROR] = 1'h1;
    if (ev.form_err)
      next_st.flags[`CGC_GIT_GENERAL_FORM_ERROR] = 1'h1;
    if (ev.stuff_err)
      next_st.flags[`CGC_GIT_GENERAL_STUFF_ERROR] = 1'h1;
    if (ev.ack_err)
      next_st.flags[`CGC_GIT_GENERAL_ACK_ERROR] = 1'h1;
    // Prescaled timer with rollover flag
    if (running)
    begin
      next_st.presc = tick ? 8'h00 : st.presc + 8'h01;
      if (tick)
      begin
        next_st.timer = st.timer + 16'h0001;
        if (st.timer == `CGC_TIMER_MAX)
          next_st.flags[`CGC_GIT_TIMER_OVERRUN_FLAG] = 1'h1;
      end
    end
    // Time-triggered capture at start of frame or last end-of-frame bit
    if (st.gcon[`CGC_GCON_TTC])
    begin
      if (st.gcon[`CGC_GCON_SYNC] ? ev.eof_last : ev.sof)
        next_st.capture = st.timer;
    end
    // Error counters, frozen while only listening; REC saturates at both ends, TEC holds at zero and at the top holds and sets bus-off
    if (!st.gcon[`CGC_GCON_LISTEN])
    begin
      if (cnt.tec_up8)
      begin
        if (st.tec > `CGC_CNT_MAX - 8'h08)
          next_st.core.bus_off = 1'h1;
        else
          next_st.tec = st.tec + 8'h08;
      end
      else if (cnt.tec_down && st.tec != 8'h00)
        next_st.tec = st.tec - 8'h01;
      if (cnt.rec_up8)
        next_st.rec = (st.rec > `CGC_CNT_MAX - 8'h08) ? `CGC_CNT_MAX : st.rec + 8'h08;
      else if (cnt.rec_up1 && st.rec != `CGC_CNT_MAX)
        next_st.rec = st.rec + 8'h01;
      else if (cnt.rec_down && st.rec != 8'h00)
        next_st.rec = st.rec - 8'h01;
    end
    // Controls toward the protocol engine
    next_st.core.run = (next_st.mode == cgc_pkg::CGC_RUN) ||
                       (next_st.mode == cgc_pkg::CGC_STOP);
    next_st.core.clk_en = next_st.core.run;
    next_st.core.overload_req = next_st.gcon[`CGC_GCON_OVERLOAD_REQUEST];
    next_st.core.abort_req = next_st.gcon[`CGC_GCON_ABORT_REQUEST];
    next_st.core.tt_mode = next_st.gcon[`CGC_GCON_TTC];
    next_st.core.listen_only = next_st.gcon[`CGC_GCON_LISTEN];
    next_st.core.passive = (next_st.tec >= `CGC_PASSIVE_LIM) ||
                           (next_st.rec >= `CGC_PASSIVE_LIM);
    // Bus pins: recessive unless running, active and allowed to talk
    next_st.rx_sync = {st.rx_sync[0], rx_pin};
    // Gated by the next mode so the pins go quiet in the same cycle as run drops
    next_st.rx_out = next_st.core.run ? st.rx_sync[1] : 1'h1;
    next_st.tx_pin = (next_st.core.run && !next_st.core.bus_off && !next_st.core.listen_only)
                     ? core_tx : 1'h1;
    // Buffer-full needs its own enable; general errors need theirs
    next_st.irq = (st.gie[`CGC_GIE_BUFFER_FULL_INTERRUPT_ENABLE] && st.flags[`CGC_GIT_BUFFER_OVERRUN_FLAG]) ||
                  (st.gie[`CGC_GIE_GENERAL_ERROR_INTERRUPT_ENABLE] && (|st.flags[3:0]));
    // Registered read data; unmapped addresses read zero
    if (sfr.rd)
    begin
      unique case (sfr.addr)
        `CGC_ADDR_GIT:  next_st.rdata = {|st.flags, 1'h0, st.flags};
        `CGC_ADDR_TEC:  next_st.rdata = st.tec;
        `CGC_ADDR_REC:  next_st.rdata = st.rec;
        `CGC_ADDR_TCON: next_st.rdata = st.tcon;
        `CGC_ADDR_TTCL: next_st.rdata = st.capture[7:0];
        `CGC_ADDR_TTCH: next_st.rdata = st.capture[15:8];
        `CGC_ADDR_GSTA: next_st.rdata = {1'h0, st.overload_sending, 1'h0, st.transmitter_busy, st.receiver_busy,
                                         st.core.run, st.core.bus_off, st.core.passive};
        `CGC_ADDR_GCON: next_st.rdata = st.gcon;
        `CGC_ADDR_TIML: next_st.rdata = st.timer[7:0];
        `CGC_ADDR_TIMH: next_st.rdata = st.timer[15:8];
        `CGC_ADDR_GIE:  next_st.rdata = st.gie;
        default:        next_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; software reset joins the hardware reset
  always_ff @(posedge clk)
  begin
    if (reset || st.soft_rst)
      st <= RESET_STATE;
    else
      st <= next_st;
  end

  // Outputs straight from the state register
  assign sfr_rdata   = st.rdata;
  assign tx_pin      = st.tx_pin;
  assign core_rx     = st.rx_out;
  assign core        = st.core;
  assign tt_capture  = st.capture;
  assign general_irq = st.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_OVERLOAD_REQUEST_CLEARED: assert property (
    (ev.overload_start && !wr_gcon && !st.soft_rst) |=> !st.gcon[`CGC_GCON_OVERLOAD_REQUEST])
    else $error("overload request not cleared at overload start");

  AST_START_TWO: assert property (
    (st.mode == cgc_pkg::CGC_OFF && st.gcon[`CGC_GCON_ENA] && !st.soft_rst && !sfr.wr)
    |=> (!st.core.run) [*2] ##1 (st.core.run || !st.gcon[`CGC_GCON_ENA] || st.soft_rst))
    else $error("controller start did not take two periods");

  AST_STANDBY_QUIET: assert property (
    !st.core.run |-> (tx_pin && core_rx && !core.clk_en))
    else $error("standby controller touched the bus or kept its clock");

  AST_BUSOFF_QUIET: assert property (
    $past(st.core.bus_off) && st.core.bus_off |-> tx_pin)
    else $error("bus-off node drove the bus");

  AST_STOP_WAITS: assert property (
    (st.mode == cgc_pkg::CGC_STOP && busy && !st.soft_rst) |=> st.core.run)
    else $error("controller froze during traffic");

  AST_BUF_STICKY: assert property (
    (ev.buffer_full && !st.soft_rst) |=> st.flags[`CGC_GIT_BUFFER_OVERRUN_FLAG] [*2])
    else $error("buffer overrun flag not held");

  AST_CRC_FLAG: assert property (
    (ev.crc_err && !st.soft_rst) |=> st.flags[`CGC_GIT_GENERAL_CRC_ERROR])
    else $error("crc error not flagged");

  AST_FORM_FLAG: assert property (
    (ev.form_err && !st.soft_rst) |=> st.flags[`CGC_GIT_GENERAL_FORM_ERROR])
    else $error("form error not flagged");

  AST_TIMER_WRAP: assert property (
    (tick && st.timer == `CGC_TIMER_MAX && !st.soft_rst)
    |=> (st.timer == 16'h0000 && st.flags[`CGC_GIT_TIMER_OVERRUN_FLAG]))
    else $error("timer rollover not flagged");

  AST_SOFT_RESET: assert property (
    st.soft_rst |=> (st.gcon == `CGC_RST_GCON && !st.core.run && st.tec == 8'h00))
    else $error("software reset did not clear the controller");

  AST_TEC_RO: assert property (
    (sfr.wr && sfr.addr == `CGC_ADDR_TEC && cnt == '0 && !st.soft_rst) |=> $stable(st.tec))
    else $error("transmit error count changed by a write");

  AST_PASSIVE: assert property (
    (st.tec >= `CGC_PASSIVE_LIM) |-> st.core.passive)
    else $error("error passive state not reported");

endmodule

// *** verification/cgc_bus_node.sv ***
`timescale 1ns/1ps

// Other nodes on the bus, joined to us by a wired-AND line that idles recessive high
module cgc_bus_node (
  input  wire logic tx_pin,
  input  wire logic drive_dominant,
  output logic      rx_pin
);
  // A dominant bit from any node wins over our recessive level
  assign rx_pin = tx_pin & ~drive_dominant;
endmodule

// *** verification/test_can_global_control_status.sv ***
`timescale 1ns/1ps
`include "cgc_defs.svh"

module test_can_global_control_status;
  logic                   clk;
  logic                   reset;
  cgc_pkg::cgc_sfr_type   sfr;
  logic [7:0]             sfr_rdata;
  cgc_pkg::cgc_event_type ev;
  cgc_pkg::cgc_count_type cnt;
  logic                   core_tx;
  logic                   rx_pin;
  logic                   tx_pin;
  logic                   core_rx;
  cgc_pkg::cgc_core_type  core;
  logic [15:0]            tt_capture;
  logic                   general_irq;
  logic                   dom;
  logic [15:0]            cap;
  int                     miscompares;
  int                     compares;
  int                     cycles;

  cgc_top u_cgc_top (
    .clk         (clk),
    .reset       (reset),
    .sfr         (sfr),
    .sfr_rdata   (sfr_rdata),
    .ev          (ev),
    .cnt         (cnt),
    .core_tx     (core_tx),
    .rx_pin      (rx_pin),
    .tx_pin      (tx_pin),
    .core_rx     (core_rx),
    .core        (core),
    .tt_capture  (tt_capture),
    .general_irq (general_irq)
  );

  cgc_bus_node u_cgc_bus_node (
    .tx_pin         (tx_pin),
    .drive_dominant (dom),
    .rx_pin         (rx_pin)
  );

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  // Verdict and end of run
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Register write: strobe held for one taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1'b1;
    @(posedge clk);
    #2;
    sfr.wr = 1'b0;
  endtask

  // Register read: data is registered at the taking edge
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #2;
    sfr.addr = a;
    sfr.rd = 1'b1;
    @(posedge clk);
    #2;
    sfr.rd = 1'b0;
    chk(n, {8'h00, e}, {8'h00, sfr_rdata});
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    #2;
    ev[i] = 1'b1;
    @(posedge clk);
    #2;
    ev[i] = 1'b0;
  endtask

  task automatic pulse_cnt(input int i);
    @(posedge clk);
    #2;
    cnt[i] = 1'b1;
    @(posedge clk);
    #2;
    cnt[i] = 1'b0;
  endtask

  // Bounded wait for the running flag to reach a level
  task automatic wait_run(input logic v);
    for (int n = 0; n < 8 && core.run !== v; n++)
      wait_cyc(1);
  endtask

  // Main sequence
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    sfr = '0;
    ev = '0;
    cnt = '0;
    core_tx = 1'b1;
    dom = 1'b0;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    #2;
    reset = 1'b0;
    rd_chk("tec", `CGC_ADDR_TEC, 8'h00);
    rd_chk("rec", `CGC_ADDR_REC, 8'h00);
    rd_chk("gcon", `CGC_ADDR_GCON, 8'h00);
    rd_chk("gie", `CGC_ADDR_GIE, 8'hc0);
    rd_chk("gsta", `CGC_ADDR_GSTA, 8'h00);
    rd_chk("unmapped", 8'h90, 8'h00);
    // Standby keeps the line recessive and the receiver idle
    core_tx = 1'b0;
    dom = 1'b1;
    wait_cyc(3);
    chk("tx_pin", 16'h0001, {15'h0, tx_pin});
    chk("core_rx", 16'h0001, {15'h0, core_rx});
    chk("clk_en", 16'h0000, {15'h0, core.clk_en});
    core_tx = 1'b1;
    dom = 1'b0;
    wr_reg(`CGC_ADDR_TCON, 8'h03);
    rd_chk("tcon", `CGC_ADDR_TCON, 8'h03);
    wr_reg(`CGC_ADDR_TEC, 8'h55);
    rd_chk("tec ro", `CGC_ADDR_TEC, 8'h00);
    // Counter steps, with saturation at zero
    pulse_cnt(0);
    pulse_cnt(2);
    pulse_cnt(2);
    pulse_cnt(0);
    pulse_cnt(4);
    pulse_cnt(3);
    rd_chk("rec cnt", `CGC_ADDR_REC, 8'h01);
    rd_chk("tec cnt", `CGC_ADDR_TEC, 8'h07);
    // Enable takes two periods before running
    wr_reg(`CGC_ADDR_GCON, 8'h02);
    chk("run early", 16'h0000, {15'h0, core.run});
    wait_cyc(1);
    chk("run early", 16'h0000, {15'h0, core.run});
    wait_run(1'b1);
    chk("run", 16'h0001, {15'h0, core.run});
    chk("clk_en", 16'h0001, {15'h0, core.clk_en});
    rd_chk("enabled_state", `CGC_ADDR_GSTA, 8'h04);
    core_tx = 1'b0;
    dom = 1'b1;
    wait_cyc(3);
    chk("tx drive", 16'h0000, {15'h0, tx_pin});
    chk("rx follow", 16'h0000, {15'h0, core_rx});
    core_tx = 1'b1;
    dom = 1'b0;
    // Error flags, masking and write-one-to-clear
    pulse(2);
    wait_cyc(2);
    chk("irq masked", 16'h0000, {15'h0, general_irq});
    wr_reg(`CGC_ADDR_GIT, 8'h04);
    wr_reg(`CGC_ADDR_GIE, 8'hc6);
    for (int i = 0; i < 5; i++)
    begin
      pulse(i);
      rd_chk("git", `CGC_ADDR_GIT, 8'h80 | (8'h01 << i));
      chk("irq", 16'h0001, {15'h0, general_irq});
      wr_reg(`CGC_ADDR_GIT, 8'h01 << i);
      rd_chk("git clr", `CGC_ADDR_GIT, 8'h00);
    end
    // Overload request and status while busy
    wr_reg(`CGC_ADDR_GCON, 8'hc2);
    wait_cyc(1);
    chk("ovl req", 16'h0001, {15'h0, core.overload_req});
    chk("abort req", 16'h0001, {15'h0, core.abort_req});
    pulse(9);
    rd_chk("overload_request clr", `CGC_ADDR_GCON, 8'h82);
    ev[8] = 1'b1;
    wait_cyc(2);
    rd_chk("overload_sending", `CGC_ADDR_GSTA, 8'h44);
    ev[8] = 1'b0;
    ev[6] = 1'b1;
    wait_cyc(2);
    rd_chk("transmitter_busy", `CGC_ADDR_GSTA, 8'h14);
    ev[6] = 1'b0;
    ev[7] = 1'b1;
    wait_cyc(2);
    rd_chk("transmitter_busy tx", `CGC_ADDR_GSTA, 8'h14);
    // Disable lets the frame in flight finish
    wr_reg(`CGC_ADDR_GCON, 8'h00);
    wait_cyc(4);
    chk("run busy", 16'h0001, {15'h0, core.run});
    ev[7] = 1'b0;
    wait_run(1'b0);
    chk("run off", 16'h0000, {15'h0, core.run});
    rd_chk("enabled_state off", `CGC_ADDR_GSTA, 8'h00);
    // Time-triggered capture points
    wr_reg(`CGC_ADDR_GCON, 8'h22);
    wait_run(1'b1);
    chk("tt mode", 16'h0001, {15'h0, core.tt_mode});
    wait_cyc(12);
    pulse(11);
    wait_cyc(1);
    cap = tt_capture;
    chk("sof cap", 16'h0001, {15'h0, cap != 16'h0000});
    wr_reg(`CGC_ADDR_GCON, 8'h32);
    wait_cyc(12);
    pulse(11);
    wait_cyc(1);
    chk("sof ignored", cap, tt_capture);
    pulse(10);
    wait_cyc(1);
    chk("eof cap", 16'h0001, {15'h0, tt_capture != cap});
    // Software reset returns everything to reset values
    wr_reg(`CGC_ADDR_GCON, 8'h01);
    wait_cyc(3);
    chk("run rst", 16'h0000, {15'h0, core.run});
    rd_chk("gcon rst", `CGC_ADDR_GCON, 8'h00);
    rd_chk("tec rst", `CGC_ADDR_TEC, 8'h00);
    rd_chk("gie rst", `CGC_ADDR_GIE, 8'hc0);
    final_report();
  end
endmodule
